// ==== ivs_vector_select.v ====
`timescale 1ns/100ps
// Contract
// - Control register bit 15 selects table
// - Alternate bit set uses alternate table
// - Alternate table follows primary table
// - Both tables share one slot order
// - Reset issues no vector
// - Reset clears registers, PC to zero
// - Request 0 external zero, vector 8
// - Requests 1-3 capture, compare, timer one
// - Requests 5-8 capture, compare, timers
// - Requests 9,10 serial error and done
// - Requests 11-13 uart and converter
// - Requests 16,17 i2c target, controller
// - Requests 19,20 change notice, external one
// - Requests 22,23 capture seven, eight
// - Request 29 external two, vector 37
// - 24-bit slots, lower position wins
`include "ivs_defines.vh"
module ivs_vector_select #(
   parameter IRQ_COUNT = `IVS_IRQ_COUNT
) (
   input wire ref_clk,
   input wire rst,
   input wire ctrl_wr,
   input wire [15:0] ctrl_wdata,
   output wire [15:0] int_control_two,
   input wire [IRQ_COUNT-1:0] irq_pending,
   input wire vec_ack,
   output wire vec_valid,
   output wire [6:0] vec_number,
   output wire [23:0] vec_addr,
   output wire alt_table_select,
   output wire [23:0] reset_pc
);

// ==========================================================
// Helpers
// Base of the table in use; the alternate one sits right after
function [23:0] ivs_table_base;
   input alt;
   begin
      if (alt) begin
         ivs_table_base = `IVS_VEC_ADDR_BASE +
            `IVS_ALT_TABLE_OFFSET;
      end else begin
         ivs_table_base = `IVS_VEC_ADDR_BASE;
      end
   end
endfunction

function [23:0] ivs_addr;
   input [6:0] vnum;
   input alt;
   begin
      // Two address words per slot, same order in both tables
      ivs_addr = ivs_table_base(alt) + {16'h0000, vnum, 1'b0};
   end
endfunction

// ==========================================================
// Control register
reg [15:0] ctrl_reg;
reg [15:0] ctrl_next;
// Only bit 15 acts here; the rest is kept for software
always @* begin
   ctrl_next = ctrl_reg;
   if (ctrl_wr) begin
      ctrl_next = ctrl_wdata;
   end
end
always @(posedge ref_clk) begin
   if (rst) begin
      ctrl_reg <= `IVS_CTRL_RESET;
   end else begin
      ctrl_reg <= ctrl_next;
   end
end
assign int_control_two = ctrl_reg;
assign alt_table_select = ctrl_reg[`IVS_ALT_SEL_BIT];
// Reset takes PC to zero without any vector fetch
assign reset_pc = `IVS_RESET_PC;

// ==========================================================
// Source map and natural priority
// Wired sources; every number missing below is reserved
localparam [6:0] REQ_EXT_IRQ_ZERO = 7'h00;
localparam [6:0] REQ_CAPTURE_CH_ONE = 7'h01;
localparam [6:0] REQ_COMPARE_CH_ONE = 7'h02;
localparam [6:0] REQ_TIMER_ONE_EVENT = 7'h03;
localparam [6:0] REQ_CAPTURE_CH_TWO = 7'h05;
localparam [6:0] REQ_COMPARE_CH_TWO = 7'h06;
localparam [6:0] REQ_TIMER_TWO_EVENT = 7'h07;
localparam [6:0] REQ_TIMER_THREE_EVENT = 7'h08;
localparam [6:0] REQ_SPI_ERROR_EVENT = 7'h09;
localparam [6:0] REQ_SPI_DONE_EVENT = 7'h0A;
localparam [6:0] REQ_UART_RECEIVE_EVENT = 7'h0B;
localparam [6:0] REQ_UART_TRANSMIT_EVENT = 7'h0C;
localparam [6:0] REQ_CONVERTER_DONE_EVENT = 7'h0D;
localparam [6:0] REQ_I2C_TARGET_EVENT = 7'h10;
localparam [6:0] REQ_I2C_CONTROLLER_EVENT = 7'h11;
localparam [6:0] REQ_CHANGE_NOTICE_EVENT = 7'h13;
localparam [6:0] REQ_EXT_IRQ_ONE = 7'h14;
localparam [6:0] REQ_CAPTURE_CH_SEVEN = 7'h16;
localparam [6:0] REQ_CAPTURE_CH_EIGHT = 7'h17;
localparam [6:0] REQ_EXT_IRQ_TWO = 7'h1D;

// Numbers without an entry have no source and never dispatch
function ivs_src_live;
   input [6:0] req;
   begin
      case (req)
         REQ_EXT_IRQ_ZERO: ivs_src_live = 1'b1;
         REQ_CAPTURE_CH_ONE: ivs_src_live = 1'b1;
         REQ_COMPARE_CH_ONE: ivs_src_live = 1'b1;
         REQ_TIMER_ONE_EVENT: ivs_src_live = 1'b1;
         REQ_CAPTURE_CH_TWO: ivs_src_live = 1'b1;
         REQ_COMPARE_CH_TWO: ivs_src_live = 1'b1;
         REQ_TIMER_TWO_EVENT: ivs_src_live = 1'b1;
         REQ_TIMER_THREE_EVENT: ivs_src_live = 1'b1;
         REQ_SPI_ERROR_EVENT: ivs_src_live = 1'b1;
         REQ_SPI_DONE_EVENT: ivs_src_live = 1'b1;
         REQ_UART_RECEIVE_EVENT: ivs_src_live = 1'b1;
         REQ_UART_TRANSMIT_EVENT: ivs_src_live = 1'b1;
         REQ_CONVERTER_DONE_EVENT: ivs_src_live = 1'b1;
         REQ_I2C_TARGET_EVENT: ivs_src_live = 1'b1;
         REQ_I2C_CONTROLLER_EVENT: ivs_src_live = 1'b1;
         REQ_CHANGE_NOTICE_EVENT: ivs_src_live = 1'b1;
         REQ_EXT_IRQ_ONE: ivs_src_live = 1'b1;
         REQ_CAPTURE_CH_SEVEN: ivs_src_live = 1'b1;
         REQ_CAPTURE_CH_EIGHT: ivs_src_live = 1'b1;
         REQ_EXT_IRQ_TWO: ivs_src_live = 1'b1;
         default: ivs_src_live = 1'b0;
      endcase
   end
endfunction

// Vector number of a request; results stay below 7 bits
function [6:0] ivs_vec_num;
   input [6:0] req;
   begin
      ivs_vec_num = req + `IVS_VEC_OFFSET;
   end
endfunction

// Level view only: a request that drops before its slot frees is lost
reg [IRQ_COUNT-1:0] irq_live;
integer k;
always @* begin
   irq_live = {IRQ_COUNT{1'b0}};
   for (k = 0; k < IRQ_COUNT; k = k + 1) begin
      irq_live[k] = irq_pending[k] & ivs_src_live(k[6:0]);
   end
end

reg [6:0] pick_next;
reg hit_next;
integer i;
// Full scan every cycle: depth traded for no added latency
always @* begin
   pick_next = 7'h00;
   hit_next = 1'b0;
   // Descending scan so the lowest request wins
   for (i = IRQ_COUNT - 1; i >= 0; i = i - 1) begin
      if (irq_live[i]) begin
         pick_next = i[6:0];
         hit_next = 1'b1;
      end
   end
end

// ==========================================================
// Vector output, held until the core acknowledges
reg valid_reg;
reg valid_next;
reg [6:0] vnum_reg;
reg [6:0] vnum_next;
reg [23:0] vaddr_reg;
reg [23:0] vaddr_next;
// A taken vector frees the slot on the same edge: back to back
wire slot_free = !valid_reg || vec_ack;
always @* begin
   valid_next = valid_reg;
   vnum_next = vnum_reg;
   vaddr_next = vaddr_reg;
   if (slot_free) begin
      if (hit_next) begin
         valid_next = 1'b1;
         vnum_next = ivs_vec_num(pick_next);
         // Table choice is latched here; later flips do not move it
         vaddr_next = ivs_addr(ivs_vec_num(pick_next),
            alt_table_select);
      end else begin
         // Nothing live: idle outputs read back as zero
         valid_next = 1'b0;
         vnum_next = 7'h00;
         vaddr_next = 24'h000000;
      end
   end
end

// Data outputs leave flip-flops only
always @(posedge ref_clk) begin
   if (rst) begin
      // A reset drops any waiting vector; none is issued for it
      valid_reg <= 1'b0;
      vnum_reg <= 7'h00;
      vaddr_reg <= 24'h000000;
   end else begin
      valid_reg <= valid_next;
      vnum_reg <= vnum_next;
      vaddr_reg <= vaddr_next;
   end
end
assign vec_valid = valid_reg;
assign vec_number = vnum_reg;
assign vec_addr = vaddr_reg;

endmodule

// ==== ivs_defines.vh ====
`ifndef IVS_DEFINES_VH
`define IVS_DEFINES_VH
// ==========================================================
// Control register layout
`define IVS_ALT_SEL_BIT 15
`define IVS_CTRL_RESET 16'h0000
// ==========================================================
// Vector map
`define IVS_VEC_OFFSET 7'h08
`define IVS_VEC_ADDR_BASE 24'h000004
`define IVS_ALT_TABLE_OFFSET 24'h000100
`define IVS_RESET_PC 24'h000000
`define IVS_IRQ_COUNT 46
`define IVS_SRC_MASK 46'h0000_20DB_3FEF
`endif

// ==== ivs_chk.sv ====
`timescale 1ns/100ps
`include "ivs_defines.vh"
module ivs_chk(input wire ref_clk,input wire rst,
input wire [15:0] int_control_two,input wire vec_ack,
input wire vec_valid,input wire [6:0] vec_number,
input wire [23:0] vec_addr,input wire alt_table_select,
input wire [23:0] reset_pc);
default clocking @(posedge ref_clk); endclocking
default disable iff (rst);
property p_idle;!vec_valid|->vec_addr==0;endproperty
a_idle:assert property(p_idle)else $error("idle");
property p_map;vec_valid|->vec_addr[7:0]=={vec_number,1'b0}+8'h04
&&vec_addr[23:9]==15'h0000;endproperty
a_map:assert property(p_map)else $error("map");
property p_hold;vec_valid&&!vec_ack|=>$stable(vec_addr);endproperty
a_hold:assert property(p_hold)else $error("hold");
property p_alt;alt_table_select==int_control_two[15];endproperty
a_alt:assert property(p_alt)else $error("alt");
property p_pc;reset_pc==24'h000000;endproperty
a_pc:assert property(p_pc)else $error("pc");
localparam [45:0] LIVE=`IVS_SRC_MASK;
property p_live;vec_valid|->vec_number>=7'h08&&vec_number<=7'h35
&&LIVE[vec_number-7'h08];endproperty
a_live:assert property(p_live)else $error("live");
property p_latch;vec_valid&&($past(!vec_valid)||$past(vec_ack))|->
vec_addr[8]==$past(alt_table_select);endproperty
a_latch:assert property(p_latch)else $error("latch");
cover property(vec_valid&&vec_ack);
cover property(vec_valid&&vec_addr[8]);
cover property(vec_valid&&!vec_ack);
endmodule
bind ivs_vector_select ivs_chk u_chk(.*);

// ==== ivs_core_model.sv ====
`timescale 1ns/100ps
`include "ivs_defines.vh"
module ivs_core_model(
input wire ref_clk,
input wire [23:0] vec_addr,
output reg vec_ack,
output wire [23:0] fetched_handler);
// Program memory words as the core sees both vector tables
reg [23:0] prog_mem[0:511];
integer v;
initial begin vec_ack=0;
for(v=0;v<512;v=v+1)prog_mem[v]=24'h000200;
for(v=8;v<54;v=v+1)if((`IVS_SRC_MASK>>(v-8))&1)begin
prog_mem[4+2*v]=24'h000400+v;prog_mem[260+2*v]=24'h000400+v;
end
end
assign fetched_handler=prog_mem[vec_addr[8:0]];
// Stalls at random, as a busy core would
always @(negedge ref_clk) vec_ack<=$urandom%3==0;
endmodule

// ==== interrupt_vector_selection_bench.sv ====
`timescale 1ns/100ps
`include "ivs_defines.vh"
module interrupt_vector_selection_bench;
reg ref_clk=0,rst=1,ctrl_wr=0,a;reg [15:0] ctrl_wdata=0;
reg [45:0] irq_pending=0;wire vec_ack,vec_valid,alt_table_select;
wire [6:0] vec_number;wire [23:0] vec_addr,reset_pc,fetched_handler;
wire [15:0] int_control_two;reg [30:0] exp_q[$];reg [30:0] x;
integer fail_count=0,total_checks=0,cyc=0,n,m,e,i;
always #2 ref_clk=~ref_clk;
ivs_core_model u_core(.ref_clk(ref_clk),.vec_addr(vec_addr),
.vec_ack(vec_ack),.fetched_handler(fetched_handler));
ivs_vector_select u_ivs_vector_select(.ref_clk(ref_clk),.rst(rst),
.ctrl_wr(ctrl_wr),.ctrl_wdata(ctrl_wdata),.vec_ack(vec_ack),
.int_control_two(int_control_two),.irq_pending(irq_pending),
.vec_valid(vec_valid),.vec_number(vec_number),.vec_addr(vec_addr),
.alt_table_select(alt_table_select),.reset_pc(reset_pc));
task chk(input [30:0] g,input [30:0] x);begin
total_checks=total_checks+1;
if(g!==x)begin $display("CHECK FAILED %0t %h %h",$time,g,x);
fail_count=fail_count+1;end end endtask
task end_of_test;begin
if(fail_count==0&&total_checks>0)$display("All tests passed");
else $display("Some tests failed");
$finish;end endtask
always @(posedge ref_clk)begin cyc=cyc+1;
if(cyc>9000)begin fail_count=fail_count+1;end_of_test;end
else if(!rst&&vec_valid===1'b1&&vec_ack===1'b1)begin
x=exp_q.pop_front();
chk({vec_number,vec_addr},x);
chk(fetched_handler,24'h000400+x[30:24]);
end
end
initial begin n=$urandom(95);repeat(8)@(negedge ref_clk);rst=0;
for(i=0;i<200;i=i+1)begin
if(i==100)begin rst=1;repeat(2)@(negedge ref_clk);
chk(int_control_two,16'h0000);
chk(vec_valid,1'b0);
chk(reset_pc,24'h000000);
rst=0;end
do n=$urandom%30;while(!((`IVS_SRC_MASK>>n)&1));
do m=$urandom%30;while(!((`IVS_SRC_MASK>>m)&1));
a=$urandom%2;ctrl_wdata=$urandom;ctrl_wdata[15]=a;ctrl_wr=1;
@(negedge ref_clk)ctrl_wr=0;e=(n<m?n:m)+8;
chk(int_control_two,ctrl_wdata);
// Reserved lines and a later live one must lose to the lowest
irq_pending=(46'h1<<n)|(46'h1<<m)|(~`IVS_SRC_MASK&{$urandom,$urandom});
exp_q.push_back({e[6:0],24'h000004+{e[22:0],1'b0}+{a,8'h00}});
@(negedge ref_clk)irq_pending=0;
while(vec_valid!==1'b0)@(negedge ref_clk);
end
end_of_test;end
endmodule
